// >>> core/pif_pkg.sv
/*
   Constants and carrier types for the peripheral interrupt flag block.
   Assumes a 32-bit Avalon-MM master with byte addresses and a single core clock.
*/
package pif_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_FLAGS_B   = 6'h10;
   localparam logic [5:0] IDX_ENABLES_B = 6'h11;
   localparam logic [5:0] IDX_FLAGS_A   = 6'h16;
   localparam logic [5:0] IDX_ENABLES_A = 6'h17;
   localparam logic [5:0] IDX_FLAG_CLR  = 6'h18;

   // Flag bit positions, first flag register
   localparam int BIT_PORT_CHANGE = 7;
   localparam int BIT_TIMER_THREE = 6;
   localparam int BIT_TIMER_TWO   = 5;
   localparam int BIT_TIMER_ONE   = 4;
   localparam int BIT_CAPTURE_TWO = 3;
   localparam int BIT_CAPTURE_ONE = 2;
   localparam int BIT_TX_EMPTY    = 1;
   localparam int BIT_RX_FULL     = 0;
   // Second flag register
   localparam int BIT_SYNC_PORT   = 7;
   localparam int BIT_BUS_COLL    = 6;
   localparam int BIT_CONV_DONE   = 5;
   localparam int BIT_CAPTURE_FOUR  = 3;
   localparam int BIT_CAPTURE_THREE = 2;

   // Capture pin vector positions
   localparam int CAP_ONE   = 0;
   localparam int CAP_TWO   = 1;
   localparam int CAP_THREE = 2;
   localparam int CAP_FOUR  = 3;

   localparam logic [7:0] SW_MASK_A     = 8'hFC;
   localparam logic [7:0] SW_MASK_B     = 8'hEC;
   localparam logic [7:0] FLAGS_A_RST   = 8'h02;
   localparam logic [7:0] FLAGS_B_RST   = 8'h02;
   localparam logic [7:0] ENABLES_RST   = 8'h00;
   localparam logic [7:0] ENABLES_B_MSK = 8'hEF;
   localparam logic [15:0] T3_TOP       = 16'hFFFF;

   typedef struct packed {
      logic [7:0]  timer_one_count;
      logic [7:0]  timer_two_count;
      logic [15:0] timer_three_count;
      logic [7:0]  period_one;
      logic [7:0]  period_two;
      logic [15:0] period_three_pair;
      logic        capture_period_select;
      logic        wide_timer_mode;
   } pif_timers_t;

   typedef struct packed {
      logic serial_a_tx_empty;
      logic serial_a_rx_full;
      logic serial_b_tx_empty;
      logic serial_b_rx_full;
   } pif_serial_t;

   typedef struct packed {
      logic sync_port_event;
      logic bus_collision;
      logic conversion_done;
   } pif_misc_t;

   typedef struct packed {
      logic [7:0]  pb_s1;
      logic [7:0]  pb_s2;
      logic [7:0]  pb_latch;
      logic [3:0]  cap_s1;
      logic [3:0]  cap_s2;
      logic [3:0]  cap_prev;
      logic [7:0]  t1_prev;
      logic [7:0]  t2_prev;
      logic [15:0] t3_prev;
      logic [7:0]  flags_a;
      logic [7:0]  flags_b;
      logic [7:0]  enables_a;
      logic [7:0]  enables_b;
      logic        ack;
      logic [31:0] rdata;
      logic        irq;
   } pif_state_t;

endpackage

// >>> core/pif_flags.sv
/*
   Peripheral interrupt flag registers with enables, Avalon-MM slave access,
   a write-one-to-clear register and one level interrupt output.
   Assumes timer counts, periods, serial buffer levels and misc events come from
   logic on mclk_in; port B and capture pins come from outside and are synchronised.
*/
// How it works
// [RULE_01] Port-change flag sets every cycle port B differs from its latched copy.
// [RULE_02] With capture_period_select high the timer-three flag sets on timer-three overflow.
// [RULE_03] With capture_period_select low the timer-three flag sets on rollover from its period.
// [RULE_04] Timer-two flag sets when timer two rolls to zero from its period.
// [RULE_05] In 8-bit mode the timer-one flag sets when timer one rolls to zero from its period.
// [RULE_06] In wide mode the timer-one flag sets when the joined count rolls from the joined period.
// [RULE_07] Capture one and two flags set on a capture edge at their pins.
// [RULE_08] First transmit flag reads 1 while that transmit buffer is empty.
// [RULE_09] First receive flag reads 1 while that receive buffer holds a word.
// [RULE_10] Transmit-empty flags follow hardware only and ignore writes.
// [RULE_11] Receive-full flags follow hardware only and clear when the buffer is read out.
// [RULE_12] Reset leaves bits 6 to 2 clear, transmit-empty 1 and receive-full 0.
// [RULE_13] An interrupt is asked for only while a flag and its enable are both 1.
// [RULE_14] Second flag register carries sync port, collision, conversion, a zero bit, captures and serial b.
// [RULE_15] Writable flags stay set until cleared by software, and a hardware set beats a clear.
`timescale 1ns/10ps
module pif_flags
(
   input  wire logic                 mclk_in,
   input  wire logic                 rst_in,
   input  wire logic [7:0]           avs_address_in,
   input  wire logic                 avs_read_in,
   input  wire logic                 avs_write_in,
   input  wire logic [31:0]          avs_writedata_in,
   input  wire logic [3:0]           avs_byteenable_in,
   output logic      [31:0]          avs_readdata_out,
   output logic                      avs_waitrequest_out,
   input  wire logic [7:0]           port_b_inputs_in,
   input  wire logic                 port_b_latch_in,
   input  wire logic [3:0]           capture_pins_in,
   input  wire pif_pkg::pif_timers_t timers_in,
   input  wire pif_pkg::pif_serial_t serial_in,
   input  wire pif_pkg::pif_misc_t   misc_in,
   output logic                      irq_out
);

   pif_pkg::pif_state_t st_reg;
   pif_pkg::pif_state_t st_next;

   logic [7:0]  set_a;
   logic [7:0]  set_b;
   logic [7:0]  clr_a;
   logic [7:0]  clr_b;
   logic [7:0]  hw_a;
   logic [7:0]  hw_b;
   logic [3:0]  cap_edge;
   logic [5:0]  idx;
   logic        req;
   logic        wr_go;
   logic        wr_lo;
   logic [31:0] rd_mux;
   logic        t1_wrap;
   logic        t2_wrap;
   logic        wide_wrap;
   logic        t3_wrap;
   logic        t3_ovf;

   assign idx = avs_address_in[7:2];
   assign req = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & ~st_reg.ack;
   assign avs_readdata_out = st_reg.rdata;
   assign irq_out = st_reg.irq;

   always_comb
   begin
      st_next = st_reg;
      set_a = 8'h00;
      set_b = 8'h00;
      clr_a = 8'h00;
      clr_b = 8'h00;
      hw_a = 8'h00;
      hw_b = 8'h00;
      rd_mux = 32'h0000_0000;

      // Two-stage synchronisers for pins
      st_next.pb_s1 = port_b_inputs_in;
      st_next.pb_s2 = st_reg.pb_s1;
      st_next.cap_s1 = capture_pins_in;
      st_next.cap_s2 = st_reg.cap_s1;
      st_next.cap_prev = st_reg.cap_s2;
      cap_edge = st_reg.cap_s2 & ~st_reg.cap_prev;
      if (port_b_latch_in)
      begin
         st_next.pb_latch = st_reg.pb_s2;
      end

      // Timer rollover detection from last cycle's count
      st_next.t1_prev = timers_in.timer_one_count;
      st_next.t2_prev = timers_in.timer_two_count;
      st_next.t3_prev = timers_in.timer_three_count;
      t1_wrap = (st_reg.t1_prev == timers_in.period_one)
                && (timers_in.timer_one_count == 8'h00);
      t2_wrap = (st_reg.t2_prev == timers_in.period_two)
                && (timers_in.timer_two_count == 8'h00);
      wide_wrap = ({st_reg.t2_prev, st_reg.t1_prev}
                   == {timers_in.period_two, timers_in.period_one})
                  && ({timers_in.timer_two_count, timers_in.timer_one_count} == 16'h0000);
      t3_wrap = (st_reg.t3_prev == timers_in.period_three_pair)
                && (timers_in.timer_three_count == 16'h0000);
      t3_ovf = (st_reg.t3_prev == pif_pkg::T3_TOP)
               && (timers_in.timer_three_count == 16'h0000);

      set_a[pif_pkg::BIT_PORT_CHANGE] = st_reg.pb_s2 != st_reg.pb_latch;   // see [RULE_01]
      if (timers_in.capture_period_select)
      begin
         set_a[pif_pkg::BIT_TIMER_THREE] = t3_ovf;                        // see [RULE_02]
      end
      else
      begin
         set_a[pif_pkg::BIT_TIMER_THREE] = t3_wrap;                       // see [RULE_03]
      end
      set_a[pif_pkg::BIT_TIMER_TWO] = t2_wrap;                            // see [RULE_04]
      if (timers_in.wide_timer_mode)
      begin
         set_a[pif_pkg::BIT_TIMER_ONE] = wide_wrap;                       // see [RULE_06]
      end
      else
      begin
         set_a[pif_pkg::BIT_TIMER_ONE] = t1_wrap;                         // see [RULE_05]
      end
      set_a[pif_pkg::BIT_CAPTURE_ONE] = cap_edge[pif_pkg::CAP_ONE];       // see [RULE_07]
      set_a[pif_pkg::BIT_CAPTURE_TWO] = cap_edge[pif_pkg::CAP_TWO];       // see [RULE_07]

      set_b[pif_pkg::BIT_SYNC_PORT] = misc_in.sync_port_event;            // see [RULE_14]
      set_b[pif_pkg::BIT_BUS_COLL] = misc_in.bus_collision;
      set_b[pif_pkg::BIT_CONV_DONE] = misc_in.conversion_done;
      set_b[pif_pkg::BIT_CAPTURE_THREE] = cap_edge[pif_pkg::CAP_THREE];
      set_b[pif_pkg::BIT_CAPTURE_FOUR] = cap_edge[pif_pkg::CAP_FOUR];

      // Buffer-state flags mirror the serial units
      hw_a[pif_pkg::BIT_TX_EMPTY] = serial_in.serial_a_tx_empty;          // see [RULE_08]
      hw_a[pif_pkg::BIT_RX_FULL] = serial_in.serial_a_rx_full;            // see [RULE_09]
      hw_b[pif_pkg::BIT_TX_EMPTY] = serial_in.serial_b_tx_empty;          // see [RULE_14]
      hw_b[pif_pkg::BIT_RX_FULL] = serial_in.serial_b_rx_full;            // see [RULE_14]

      // Bus slave: one wait cycle, then the request completes
      wr_go = avs_write_in & st_reg.ack & avs_byteenable_in[0];
      wr_lo = avs_write_in & st_reg.ack & avs_byteenable_in[1];
      st_next.ack = req & ~st_reg.ack;

      if (wr_go && (idx == pif_pkg::IDX_FLAG_CLR))
      begin
         clr_a = avs_writedata_in[7:0];
      end
      if (wr_lo && (idx == pif_pkg::IDX_FLAG_CLR))
      begin
         clr_b = avs_writedata_in[15:8];
      end

      // Software writes only the writable bits; set wins over clear
      if (wr_go && (idx == pif_pkg::IDX_FLAGS_A))
      begin
         st_next.flags_a = avs_writedata_in[7:0];
      end
      if (wr_go && (idx == pif_pkg::IDX_FLAGS_B))
      begin
         st_next.flags_b = avs_writedata_in[7:0];
      end
      st_next.flags_a = ((st_next.flags_a & ~clr_a) | set_a) & pif_pkg::SW_MASK_A;  // see [RULE_15]
      st_next.flags_b = ((st_next.flags_b & ~clr_b) | set_b) & pif_pkg::SW_MASK_B;  // see [RULE_15]
      st_next.flags_a = st_next.flags_a | hw_a;                           // see [RULE_10]
      st_next.flags_b = st_next.flags_b | hw_b;                           // see [RULE_11]

      if (wr_go && (idx == pif_pkg::IDX_ENABLES_A))
      begin
         st_next.enables_a = avs_writedata_in[7:0];
      end
      if (wr_go && (idx == pif_pkg::IDX_ENABLES_B))
      begin
         st_next.enables_b = avs_writedata_in[7:0] & pif_pkg::ENABLES_B_MSK;
      end

      st_next.irq = |((st_next.flags_a & st_next.enables_a)
                      | (st_next.flags_b & st_next.enables_b));          // see [RULE_13]

      unique case (idx)
         pif_pkg::IDX_FLAGS_A:   rd_mux[7:0] = st_reg.flags_a;
         pif_pkg::IDX_FLAGS_B:   rd_mux[7:0] = st_reg.flags_b;
         pif_pkg::IDX_ENABLES_A: rd_mux[7:0] = st_reg.enables_a;
         pif_pkg::IDX_ENABLES_B: rd_mux[7:0] = st_reg.enables_b;
         default:                rd_mux = 32'h0000_0000;
      endcase
      if (avs_read_in && !st_reg.ack)
      begin
         st_next.rdata = rd_mux;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         st_reg <= '0;
         st_reg.flags_a <= pif_pkg::FLAGS_A_RST;                           // see [RULE_12]
         st_reg.flags_b <= pif_pkg::FLAGS_B_RST;                           // see [RULE_14]
         st_reg.enables_a <= pif_pkg::ENABLES_RST;
         st_reg.enables_b <= pif_pkg::ENABLES_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

endmodule

// >>> verif/pif_flags_sva.sv
/*
   Bus and mirror checks on the flag block's ports.
   Assumes binding to pif_flags; reads finish one edge after waitrequest drops.
*/
`timescale 1ns/10ps
module pif_flags_sva
(
   input wire logic                 mclk_in,
   input wire logic                 rst_in,
   input wire logic [7:0]           avs_address_in,
   input wire logic                 avs_read_in,
   input wire logic                 avs_write_in,
   input wire logic [31:0]          avs_readdata_out,
   input wire logic                 avs_waitrequest_out,
   input wire pif_pkg::pif_serial_t serial_in
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff rst_in;
   // Read completing at a given register index
   sequence s_rd(logic [5:0] idx);
      avs_read_in && !avs_waitrequest_out && avs_address_in[7:2] == idx;
   endsequence
   a_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out) else $error("request not answered after one wait");
   a_idle_ready: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
      else $error("waitrequest high with no request");
   a_tx_a_mirror: assert property (s_rd(pif_pkg::IDX_FLAGS_A) |->
      avs_readdata_out[1] == $past(serial_in.serial_a_tx_empty, 2)) else $error("tx a bad");
   a_rx_a_mirror: assert property (s_rd(pif_pkg::IDX_FLAGS_A) |->
      avs_readdata_out[0] == $past(serial_in.serial_a_rx_full, 2)) else $error("rx a bad");
   a_tx_b_mirror: assert property (s_rd(pif_pkg::IDX_FLAGS_B) |->
      avs_readdata_out[1] == $past(serial_in.serial_b_tx_empty, 2)) else $error("tx b bad");
   a_rx_b_mirror: assert property (s_rd(pif_pkg::IDX_FLAGS_B) |->
      avs_readdata_out[0] == $past(serial_in.serial_b_rx_full, 2)) else $error("rx b bad");
   a_gap_zero: assert property (s_rd(pif_pkg::IDX_FLAGS_B) |-> !avs_readdata_out[4])
      else $error("reserved bit set");
   a_unmapped_zero: assert property (s_rd(6'h00) |-> avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
endmodule

// >>> verif/pif_flags_tb_top.sv
/*
   Self-checking bench for the flag block.
   Assumes nothing beyond the block; the bench drives every input itself.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module pif_flags_tb_top;
   logic                 mclk_in = 1'h0;
   logic                 rst_in = 1'h1;
   logic [7:0]           avs_address_in = 8'h00;
   logic                 avs_read_in = 1'h0;
   logic                 avs_write_in = 1'h0;
   logic [31:0]          avs_writedata_in = 32'h0;
   logic [3:0]           avs_byteenable_in = 4'hF;
   logic [31:0]          avs_readdata_out;
   logic                 avs_waitrequest_out;
   logic [7:0]           port_b_inputs_in = 8'h00;
   logic                 port_b_latch_in = 1'h0;
   logic [3:0]           capture_pins_in = 4'h0;
   localparam pif_pkg::pif_timers_t tdef = '{8'h01, 8'h01, 16'h0001, 8'h55, 8'h55,
      16'h5555, 1'h0, 1'h0};
   pif_pkg::pif_timers_t timers_in = tdef;
   pif_pkg::pif_serial_t serial_in = 4'hA;
   pif_pkg::pif_misc_t   misc_in = 3'h0;
   logic                 irq_out;
   int                   err_count = 0;
   int                   n_checks = 0;
   int                   cyc = 0;
   logic [31:0]          d;
   localparam logic [7:0] fa = {pif_pkg::IDX_FLAGS_A, 2'h0};
   localparam logic [7:0] fb = {pif_pkg::IDX_FLAGS_B, 2'h0};
   localparam logic [7:0] ea = {pif_pkg::IDX_ENABLES_A, 2'h0};
   localparam logic [7:0] eb = {pif_pkg::IDX_ENABLES_B, 2'h0};
   localparam logic [7:0] clr = {pif_pkg::IDX_FLAG_CLR, 2'h0};

   pif_flags i_dut (.*);

   always #50 mclk_in = ~mclk_in;
   always @(posedge mclk_in)
   begin
      cyc++;
      if (cyc > 3000)
      begin
         err_count++;
         print_verdict;
      end
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk_in);
      avs_address_in <= a;
      avs_writedata_in <= wd;
      avs_read_in <= !w;
      avs_write_in <= w;
      // Request stands until the rising edge that sees waitrequest low
      do @(posedge mclk_in); while (avs_waitrequest_out !== 1'h0);
      d = avs_readdata_out;
      avs_read_in <= 1'h0;
      avs_write_in <= 1'h0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      bus(1'h0, a, 32'h0);
      `CHK(d, {24'h0, e})
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge mclk_in);
   endtask

   // Timer condition, then all counts to zero; flag read, cleared
   task automatic ev(input pif_pkg::pif_timers_t t, input logic [7:0] e);
      timers_in <= t;
      wait_n(2);
      timers_in.timer_one_count <= 8'h00;
      timers_in.timer_two_count <= 8'h00;
      timers_in.timer_three_count <= 16'h0000;
      wait_n(2);
      rdc(fa, e);
      timers_in <= tdef;
      bus(1'h1, fa, 32'h0);
      rdc(fa, 8'h02);
   endtask

   task automatic t_reset;
      rdc(fa, 8'h02);
      rdc(fb, 8'h02);
      rdc(ea, 8'h00);
      rdc(eb, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_mirror;
      serial_in <= 4'h5;
      wait_n(3);
      rdc(fa, 8'h01);
      bus(1'h1, fa, 32'h03);
      bus(1'h1, fb, 32'h03);
      rdc(fa, 8'h01);
      rdc(fb, 8'h01);
      serial_in <= 4'hA;
      $display("test mirror done");
   endtask

   task automatic t_timer;
      ev('{8'h01, 8'h01, 16'hFFFF, 8'h55, 8'h55, 16'h5555, 1'h1, 1'h0}, 8'h42);
      ev('{8'h01, 8'h01, 16'h1234, 8'h55, 8'h55, 16'h1234, 1'h0, 1'h0}, 8'h42);
      ev('{8'h01, 8'h01, 16'hFFFF, 8'h55, 8'h55, 16'h1234, 1'h0, 1'h0}, 8'h02);
      ev('{8'h01, 8'h40, 16'h0001, 8'h55, 8'h40, 16'h5555, 1'h0, 1'h0}, 8'h22);
      ev('{8'h33, 8'h01, 16'h0001, 8'h33, 8'h55, 16'h5555, 1'h0, 1'h0}, 8'h12);
      ev('{8'h33, 8'h40, 16'h0001, 8'h33, 8'h40, 16'h5555, 1'h0, 1'h1}, 8'h32);
      ev('{8'h33, 8'h01, 16'h0001, 8'h33, 8'h55, 16'h5555, 1'h0, 1'h1}, 8'h02);
      $display("test timers done");
   endtask

   task automatic t_capt;
      capture_pins_in <= 4'hF;
      misc_in <= 3'h7;
      wait_n(1);
      misc_in <= 3'h0;
      wait_n(4);
      `CHK(irq_out, 1'h0)
      rdc(fa, 8'h0E);
      rdc(fb, 8'hEE);
      bus(1'h1, eb, 32'h80);
      wait_n(2);
      `CHK(irq_out, 1'h1)
      bus(1'h1, clr, 32'h8000);
      wait_n(2);
      `CHK(irq_out, 1'h0)
      rdc(fb, 8'h6E);
      rdc(clr, 8'h00);
      bus(1'h1, 8'h00, 32'hFF);
      rdc(8'h00, 8'h00);
      bus(1'h1, ea, 32'h02);
      wait_n(2);
      `CHK(irq_out, 1'h1)
      bus(1'h1, ea, 32'h00);
      bus(1'h1, eb, 32'h00);
      bus(1'h1, fb, 32'h00);
      bus(1'h1, fa, 32'h00);
      capture_pins_in <= 4'h0;
      $display("test capture done");
   endtask

   task automatic t_port;
      port_b_inputs_in <= 8'h01;
      wait_n(4);
      bus(1'h1, fa, 32'h0);
      rdc(fa, 8'h82);
      port_b_latch_in <= 1'h1;
      wait_n(1);
      port_b_latch_in <= 1'h0;
      wait_n(3);
      bus(1'h1, fa, 32'h0);
      rdc(fa, 8'h02);
      $display("test port done");
   endtask

   initial
   begin
      wait_n(12);
      rst_in <= 1'h0;
      t_reset;
      t_mirror;
      t_timer;
      t_capt;
      t_port;
      print_verdict;
   end
endmodule

bind pif_flags pif_flags_sva i_sva (.*);
